/* axgc_consts.vh */
// constants for the auxiliary converter step and gain-trim register bank
// Behaviour
// - gain trim is 16-bit signed word
// - result scaled by one plus trim/65536
// - gain trim resets to zero
// - step0 bit 15 enables step 0
// - gain code 00=x1, 01=x2, 1x=x4
// - step0 bits 12:5 read zero always
// - step0 bit 4 picks ground or input 7
// - positive codes 0-7 pick external inputs
// - codes 8-15 route internal sources
// - internal source forces automatic negative input
// - step0 config resets to zero
// - step1 config resets to 0001h
// - code 12 io/4, code 13 digital/2
`ifndef AXGC_CONSTS_VH
`define AXGC_CONSTS_VH
// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define AXGC_IDX_GAIN_TRIM 8'h8F
`define AXGC_IDX_STEP0 8'h90
`define AXGC_IDX_STEP1 8'h91
`define AXGC_ADDR_W 10
`define AXGC_ADDR_GAIN_TRIM 10'h23C
`define AXGC_ADDR_STEP0 10'h240
`define AXGC_ADDR_STEP1 10'h244
// ----------------------------------------
// reset values
// ----------------------------------------
`define AXGC_RST_GAIN_TRIM 16'h0000
`define AXGC_RST_STEP0 16'h0000
`define AXGC_RST_STEP1 16'h0001
// ----------------------------------------
// field positions and masks
// ----------------------------------------
`define AXGC_F_EN 15
`define AXGC_F_GAIN_HI 14
`define AXGC_F_GAIN_LO 13
`define AXGC_F_NEG 4
`define AXGC_F_POS_HI 3
`define AXGC_F_POS_LO 0
`define AXGC_STEP_WMASK 16'hE01F
// ----------------------------------------
// input and gain encodings
// ----------------------------------------
`define AXGC_NEG_GND 4'h0
`define AXGC_NEG_EXT7 4'h1
`define AXGC_NEG_AUTO 4'h2
`define AXGC_SRC_TEMP 4'h8
`define AXGC_SRC_SHORT 4'h9
`define AXGC_SRC_DAC 4'hA
`define AXGC_SRC_ANA_Q 4'hB
`define AXGC_SRC_IO_Q 4'hC
`define AXGC_SRC_DIG_H 4'hD
`define AXGC_SRC_ANALOG_POWER_INPUT 4'hE
`define AXGC_SRC_DIGITAL_POWER_INPUT 4'hF
`define AXGC_GAIN_X1 3'h1
`define AXGC_GAIN_X2 3'h2
`define AXGC_GAIN_X4 3'h4
`define AXGC_TRIM_SHIFT 16
// ----------------------------------------
// bus answers
// ----------------------------------------
`define AXGC_RESP_OKAY 2'h0
`define AXGC_RESP_SLVERR 2'h2
`endif

/* axgc_gain_mult.v */
// signed gain-trim multiplier with saturation
`timescale 1ns/100ps
module axgc_gain_mult #(
  parameter W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // sample in
  input wire [W-1:0] din,
  input wire din_valid,
  input wire [15:0] trim,
  // sample out
  output reg [W-1:0] dout_ff,
  output reg dout_valid_ff
);
  `include "axgc_consts.vh"
  // ----------------------------------------
  // product
  // ----------------------------------------
  // factor is (65536 + trim)/65536, always in 0.5 .. 1.5
  wire signed [17:0] factor = 18'sh10000 + $signed({{2{trim[15]}}, trim});
  wire signed [W+18:0] prod = $signed(din) * factor;
  wire signed [W+2:0] scaled = prod[W+18:`AXGC_TRIM_SHIFT];
  wire signed [W-1:0] max_v = {1'b0, {(W-1){1'b1}}};
  wire signed [W-1:0] min_v = {1'b1, {(W-1){1'b0}}};
  reg [W-1:0] nxt_dout;
  always @* begin
    // saturate rather than wrap near full scale
    if (scaled > $signed({{3{1'b0}}, max_v})) begin
      nxt_dout = max_v;
    end else if (scaled < $signed({{3{1'b1}}, min_v})) begin
      nxt_dout = min_v;
    end else begin
      nxt_dout = scaled[W-1:0];
    end
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      dout_ff <= {W{1'b0}};
      dout_valid_ff <= 1'b0;
    end else begin
      dout_ff <= nxt_dout;
      dout_valid_ff <= din_valid;
    end
  end
endmodule

/* axgc_regs.v */
// auxiliary converter step configuration and gain-trim registers
`timescale 1ns/100ps
`include "axgc_consts.vh"
module axgc_regs #(
  parameter DATA_W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address
  input wire [`AXGC_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp_ff,
  output reg s_axi_bvalid_ff,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [`AXGC_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata_ff,
  output reg [1:0] s_axi_rresp_ff,
  output reg s_axi_rvalid_ff,
  input wire s_axi_rready,
  // step 0 controls to the sequencer
  output wire step0_enable,
  output wire [2:0] step0_gain,
  output wire [3:0] step0_pos_select,
  output wire [3:0] step0_neg_route,
  output wire step0_internal,
  // step 1 word to the sequencer
  output wire [15:0] step1_config,
  // calibration datapath
  input wire [DATA_W-1:0] offset_corr_data,
  input wire offset_corr_valid,
  output wire [DATA_W-1:0] cal_data,
  output wire cal_valid
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  reg [15:0] gain_trim_ff;
  reg [15:0] step0_cfg_ff;
  reg [15:0] step1_cfg_ff;
  // ----------------------------------------
  // write channel
  // ----------------------------------------
  // address and data captured independently, in either order
  reg [`AXGC_ADDR_W-1:0] aw_addr_ff;
  reg aw_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg w_held_ff;
  assign s_axi_awready = !aw_held_ff && !s_axi_bvalid_ff;
  assign s_axi_wready = !w_held_ff && !s_axi_bvalid_ff;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held_ff && w_held_ff;
  wire wr_hit_gain = aw_addr_ff == `AXGC_ADDR_GAIN_TRIM;
  wire wr_hit_s0 = aw_addr_ff == `AXGC_ADDR_STEP0;
  wire wr_hit_s1 = aw_addr_ff == `AXGC_ADDR_STEP1;
  wire wr_hit = wr_hit_gain || wr_hit_s0 || wr_hit_s1;
  // merge byte lanes onto a 16-bit register
  function [15:0] merge16;
    input [15:0] old_v;
    input [31:0] wd;
    input [3:0] st;
    begin
      merge16 = old_v;
      if (st[0]) begin
        merge16[7:0] = wd[7:0];
      end
      if (st[1]) begin
        merge16[15:8] = wd[15:8];
      end
    end
  endfunction
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr_ff <= {`AXGC_ADDR_W{1'b0}};
      aw_held_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      w_held_ff <= 1'b0;
      s_axi_bvalid_ff <= 1'b0;
      s_axi_bresp_ff <= `AXGC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_addr_ff <= s_axi_awaddr;
        aw_held_ff <= 1'b1;
      end
      if (w_take) begin
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        w_held_ff <= 1'b1;
      end
      if (do_write) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid_ff <= 1'b1;
        s_axi_bresp_ff <= wr_hit ? `AXGC_RESP_OKAY : `AXGC_RESP_SLVERR;
      end else if (s_axi_bvalid_ff && s_axi_bready) begin
        s_axi_bvalid_ff <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // register update
  // ----------------------------------------
  wire [15:0] nxt_gain_trim = merge16(gain_trim_ff, w_data_ff, w_strb_ff);
  // reserved bits 12:5 never stored
  wire [15:0] nxt_step0 = merge16(step0_cfg_ff, w_data_ff, w_strb_ff) & `AXGC_STEP_WMASK;
  wire [15:0] nxt_step1 = merge16(step1_cfg_ff, w_data_ff, w_strb_ff) & `AXGC_STEP_WMASK;
  always @(posedge aclk) begin
    if (!aresetn) begin
      gain_trim_ff <= `AXGC_RST_GAIN_TRIM;
      step0_cfg_ff <= `AXGC_RST_STEP0;
      step1_cfg_ff <= `AXGC_RST_STEP1;
    end else if (do_write) begin
      if (wr_hit_gain) begin
        gain_trim_ff <= nxt_gain_trim;
      end
      if (wr_hit_s0) begin
        step0_cfg_ff <= nxt_step0;
      end
      if (wr_hit_s1) begin
        step1_cfg_ff <= nxt_step1;
      end
    end
  end
  // ----------------------------------------
  // read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid_ff;
  wire ar_take = s_axi_arvalid && s_axi_arready;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_rresp = `AXGC_RESP_OKAY;
    case (s_axi_araddr)
      `AXGC_ADDR_GAIN_TRIM: begin
        nxt_rdata = {16'h0000, gain_trim_ff};
      end
      `AXGC_ADDR_STEP0: begin
        nxt_rdata = {16'h0000, step0_cfg_ff};
      end
      `AXGC_ADDR_STEP1: begin
        nxt_rdata = {16'h0000, step1_cfg_ff};
      end
      default: begin
        nxt_rresp = `AXGC_RESP_SLVERR;
      end
    endcase
  end
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid_ff <= 1'b0;
      s_axi_rdata_ff <= 32'h00000000;
      s_axi_rresp_ff <= `AXGC_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid_ff <= 1'b1;
      s_axi_rdata_ff <= nxt_rdata;
      s_axi_rresp_ff <= nxt_rresp;
    end else if (s_axi_rvalid_ff && s_axi_rready) begin
      s_axi_rvalid_ff <= 1'b0;
    end
  end
  // ----------------------------------------
  // step 0 decode to the sequencer
  // ----------------------------------------
  wire [3:0] pos_code = step0_cfg_ff[`AXGC_F_POS_HI:`AXGC_F_POS_LO];
  wire [1:0] gain_code = step0_cfg_ff[`AXGC_F_GAIN_HI:`AXGC_F_GAIN_LO];
  assign step0_enable = step0_cfg_ff[`AXGC_F_EN];
  // codes 10 and 11 both mean x4
  assign step0_gain = (gain_code == 2'b00) ? `AXGC_GAIN_X1 :
    (gain_code == 2'b01) ? `AXGC_GAIN_X2 : `AXGC_GAIN_X4;
  assign step0_pos_select = pos_code;
  // top code bit marks temp, short, dac and supply monitors
  assign step0_internal = pos_code[3];
  // internal sources pick their own return, ignoring bit 4
  assign step0_neg_route = step0_internal ? `AXGC_NEG_AUTO :
    (step0_cfg_ff[`AXGC_F_NEG] ? `AXGC_NEG_EXT7 : `AXGC_NEG_GND);
  assign step1_config = step1_cfg_ff;
  // ----------------------------------------
  // gain calibration datapath
  // ----------------------------------------
  axgc_gain_mult #(
    .W(DATA_W)
  ) u_mult (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(offset_corr_data),
    .din_valid(offset_corr_valid),
    .trim(gain_trim_ff),
    .dout_ff(cal_data),
    .dout_valid_ff(cal_valid)
  );
endmodule

/* axgc_regs_asserts.sv */
// assertions for the step and gain-trim register bank
`timescale 1ns/100ps
`include "axgc_consts.vh"
module axgc_regs_chk #(
  parameter DATA_W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // bus
  input wire [`AXGC_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata_ff,
  input wire s_axi_rvalid_ff,
  input wire [1:0] s_axi_bresp_ff,
  input wire s_axi_bvalid_ff,
  input wire s_axi_bready,
  // step 0 and datapath
  input wire step0_enable,
  input wire [2:0] step0_gain,
  input wire [3:0] step0_pos_select,
  input wire [3:0] step0_neg_route,
  input wire step0_internal,
  input wire offset_corr_valid,
  input wire cal_valid
);
  // ----
  // helpers
  // ----
  reg [`AXGC_ADDR_W-1:0] rd_addr_ff;
  wire s0_rd = s_axi_rvalid_ff && rd_addr_ff == `AXGC_ADDR_STEP0;
  // address kept only at the take, so a step 0 read is recognised while rvalid stands
  always @(posedge aclk) begin
    if (!aresetn) rd_addr_ff <= {`AXGC_ADDR_W{1'b0}};
    else if (s_axi_arvalid && s_axi_arready) rd_addr_ff <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take; s_axi_arvalid && s_axi_arready; endsequence
  sequence b_wait; s_axi_bvalid_ff && !s_axi_bready; endsequence
  // ----
  // checks
  // ----
  a_read_answer: assert property (ar_take |=> s_axi_rvalid_ff)
    else $error("read not answered");
  a_resp_hold: assert property (b_wait |=> s_axi_bvalid_ff && $stable(s_axi_bresp_ff))
    else $error("write response dropped");
  a_auto_neg: assert property (step0_internal |-> step0_neg_route == `AXGC_NEG_AUTO)
    else $error("internal source without automatic negative");
  a_ext_neg: assert property (s0_rd && !step0_internal |->
    step0_neg_route == {3'h0, s_axi_rdata_ff[4]}) else $error("negative route wrong");
  a_gain_map: assert property (s0_rd |-> step0_gain ==
    (s_axi_rdata_ff[14] ? 3'h4 : s_axi_rdata_ff[13] ? 3'h2 : 3'h1)) else $error("gain wrong");
  a_rsvd_zero: assert property (s0_rd |-> s_axi_rdata_ff[12:5] == 8'h00)
    else $error("reserved bits set");
  a_enable_bit: assert property (s0_rd |-> step0_enable == s_axi_rdata_ff[15])
    else $error("enable mismatch");
  a_pos_route: assert property (s0_rd |-> step0_pos_select == s_axi_rdata_ff[3:0]
    && step0_internal == s_axi_rdata_ff[3]) else $error("positive route wrong");
  a_cal_latency: assert property (offset_corr_valid |=> cal_valid)
    else $error("calibrated sample late");
endmodule
bind axgc_regs axgc_regs_chk #(.DATA_W(DATA_W)) axgc_regs_chk_inst (.aclk, .aresetn,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata_ff, .s_axi_rvalid_ff,
  .s_axi_bresp_ff, .s_axi_bvalid_ff, .s_axi_bready, .step0_enable, .step0_gain,
  .step0_pos_select, .step0_neg_route, .step0_internal, .offset_corr_valid, .cal_valid);

/* axgc_regs_tb.sv */
// self-checking bench for the step and gain-trim register bank
`timescale 1ns/100ps
`include "axgc_consts.vh"
module axgc_regs_tb;
  reg aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  reg ov = 0;
  reg [9:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0;
  reg [3:0] wstrb = 0, strb = 4'hF;
  reg [15:0] od = 0, w, t;
  wire awready, wready, bvalid, arready, rvalid, en, internal, cv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [2:0] gain;
  wire [3:0] pos, neg;
  wire [15:0] s1, cd;
  logic [31:0] rd_d;
  logic [1:0] rd_r, wr_r;
  integer miscompares = 0, tests_run = 0, cyc = 0, i;
  axgc_regs axgc_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp_ff(bresp), .s_axi_bvalid_ff(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata_ff(rdata), .s_axi_rresp_ff(rresp), .s_axi_rvalid_ff(rvalid),
    .s_axi_rready(rready), .step0_enable(en), .step0_gain(gain), .step0_pos_select(pos),
    .step0_neg_route(neg), .step0_internal(internal), .step1_config(s1),
    .offset_corr_data(od), .offset_corr_valid(ov), .cal_data(cd), .cal_valid(cv));
  always #25 aclk = ~aclk;
  // ----
  // tasks
  // ----
  task chk(input [31:0] g, input [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task conclude;
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // readies sampled mid-cycle; they only move at edges, so this is the edge's view
  task wr(input [9:0] a, input [31:0] d);
    reg ra, rw, rb;
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    rb = 0;
    while (!rb) begin
      @(negedge aclk);
      ra = awready;
      rw = wready;
      rb = bvalid;
      wr_r = bresp;
      @(posedge aclk);
      if (ra) awvalid <= 1'b0;
      if (rw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input [9:0] a);
    reg ra, rv;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 0;
    while (!rv) begin
      @(negedge aclk);
      ra = arready;
      rv = rvalid;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge aclk);
      if (ra) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  function [31:0] cal_exp(input [15:0] x, input [15:0] g);
    longint p;
    p = (longint'($signed(x)) * (65536 + longint'($signed(g)))) >>> 16;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    cal_exp = {16'h0000, p[15:0]};
  endfunction
  task samp(input [15:0] x);
    od <= x;
    ov <= 1'b1;
    @(posedge aclk);
    ov <= 1'b0;
    #1;
    chk(cv, 1);
    chk(cd, cal_exp(x, t));
    @(posedge aclk);
  endtask
  // ----
  // sequence
  // ----
  always @(posedge aclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares = miscompares + 1;
      conclude;
    end
  end
  initial begin
    i = $urandom(37);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`AXGC_ADDR_STEP0);
    chk(rd_d, 0);
    rd(`AXGC_ADDR_STEP1);
    chk(rd_d, 1);
    chk(s1, 16'h0001);
    // every positive code once, gain codes cycled, other bits random
    for (i = 0; i < 16; i = i + 1) begin
      w = 16'($urandom);
      w[3:0] = i;
      w[14:13] = i[1:0];
      wr(`AXGC_ADDR_STEP0, (($urandom << 16) | w));
      chk(wr_r, `AXGC_RESP_OKAY);
      w = w & 16'hE01F;
      rd(`AXGC_ADDR_STEP0);
      chk(rd_r, `AXGC_RESP_OKAY);
      chk(rd_d, w);
      chk(internal, i[3]);
      chk(en, w[15]);
      chk(gain, w[14] ? 4 : w[13] ? 2 : 1);
      chk(neg, w[3] ? 2 : w[4]);
      chk(pos, i);
    end
    wr(10'h248, $urandom);
    chk(wr_r, `AXGC_RESP_SLVERR);
    rd(10'h248);
    chk(rd_r, `AXGC_RESP_SLVERR);
    for (i = 0; i < 4; i = i + 1) begin
      t = (i == 0) ? 16'h7FFF : (i == 1) ? 16'h8000 : (i == 2) ? 16'h0000 : 16'($urandom);
      wr(`AXGC_ADDR_GAIN_TRIM, {16'h0000, t});
      rd(`AXGC_ADDR_GAIN_TRIM);
      chk(rd_d, t);
      samp(16'h7FFF);
      samp(16'h8000);
      samp(16'($urandom));
    end
    // low byte lane only; the high byte must survive
    strb = 4'h1;
    wr(`AXGC_ADDR_GAIN_TRIM, 32'hFFFFA55A);
    strb = 4'hF;
    t = {t[15:8], 8'h5A};
    rd(`AXGC_ADDR_GAIN_TRIM);
    chk(rd_d, t);
    samp(16'h4000);
    // reset in mid-run must bring the trim back to unity
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`AXGC_ADDR_GAIN_TRIM);
    chk(rd_d, 0);
    rd(`AXGC_ADDR_STEP0);
    chk(rd_d, 0);
    chk(en, 0);
    chk(s1, 16'h0001);
    t = 16'h0000;
    samp(16'h1234);
    conclude;
  end
endmodule
